//--- design/nvmpi_consts.vh
// Purpose: constants for the nvm protection and identification block
// Assumes: 14-bit nvm words, 15-bit nvm addresses
// Notes: definitions only
`ifndef NVMPI_CONSTS_VH
`define NVMPI_CONSTS_VH
// memory configuration word fields
`define NVMPI_MCW_LVP_BIT 13
`define NVMPI_MCW_SCAN_BIT 12
`define NVMPI_MCW_UNIMP_MASK 14'h0FFC
`define NVMPI_MCW_WRT_LO 0
// code protection word fields
`define NVMPI_CPW_EEP_BIT 1
`define NVMPI_CPW_FLASH_BIT 0
`define NVMPI_CPW_UNIMP_MASK 14'h3FFC
// erased configuration value
`define NVMPI_CFG_RESET 14'h3FFF
// self-write protect field codes
`define NVMPI_WRT_OFF 2'h3
`define NVMPI_WRT_512 2'h2
`define NVMPI_WRT_4K 2'h1
`define NVMPI_WRT_ALL 2'h0
// protected range limits
`define NVMPI_WRT_512_TOP 15'h01FF
`define NVMPI_WRT_4K_TOP 15'h0FFF
`define NVMPI_FLASH_TOP 15'h1FFF
// identification space addresses
`define NVMPI_UID_BASE 16'h8000
`define NVMPI_UID0_ADDR 16'h8000
`define NVMPI_REVID_ADDR 16'h8005
`define NVMPI_DEVICE_IDENTIFIER_ADDR 16'h8006
`define NVMPI_MCW_ADDR 16'h800A
`define NVMPI_CPW_ADDR 16'h800B
// revision word layout
`define NVMPI_REV_FIXED 2'h2
// arbitrary neutral identity values
`define NVMPI_PART_CODE 14'h0123
`define NVMPI_MAJOR_REV 6'h01
`define NVMPI_MINOR_REV 6'h00
`endif

//--- design/nvmpi_wrt_check.v
// Purpose: decides whether a self-write address is protected
// Assumes: 15-bit word address into program flash
// Notes: purely combinational
`timescale 1ns/10ps
`include "nvmpi_consts.vh"
module nvmpi_wrt_check (
	input wire [1:0] wrt_field_in, // self-write protect field
	input wire [14:0] addr_in, // target flash address
	output reg protected_out // high when self-write is blocked
);
	// range compare per field code
	always @* begin
		case (wrt_field_in)
			`NVMPI_WRT_OFF: protected_out = 1'b0;
			`NVMPI_WRT_512: protected_out = (addr_in <= `NVMPI_WRT_512_TOP);
			`NVMPI_WRT_4K: protected_out = (addr_in <= `NVMPI_WRT_4K_TOP);
			default: protected_out = (addr_in <= `NVMPI_FLASH_TOP);
		endcase
	end
endmodule // nvmpi_wrt_check

//--- design/nvmpi_top.v
// Purpose: nvm protection, programming-entry and identification logic
// Assumes: code protect word arrives as a level from the fuse array; memory config word resets to erased value; pins pre-sampled here
// Notes: external = programming port, internal = cpu and self-write control
// Behaviour
// - lvp set: low-voltage entry, pin is reset
// - no lvp clear during low-voltage programming
// - high-voltage entry always accepted
// - scanner usable only when available bit set
// - unimplemented config bits read as one
// - field 11 none; 10 protects 0000-01FF
// - field 01 protects to 0FFF; 00 all
// - flash protect: external access blocked, zeros
// - cpu reads flash freely; self-write by field
// - eeprom protect: external access blocked, zeros
// - cpu reads eeprom freely
// - the two protections act independently
// - bit1 eeprom, bit0 flash, zero protects
// - four user id words, read and write
// - device id 8006h, revision id 8005h
// - id words are read-only
// - ids and config readable externally and internally
// - revision bits 13:12 read 10
// - major revision 11:6, minor 5:0
`timescale 1ns/10ps
`include "nvmpi_consts.vh"
module nvmpi_top (
	input wire clk_in, // 10 MHz clock
	input wire reset_n_in, // async reset, active low
	input wire [13:0] memory_config_word_in, // raw fuse value of memory config word
	input wire [13:0] code_protect_config_word_in, // raw fuse value of code protect word
	input wire reset_pin_enable_in, // reset pin enable fuse bit
	input wire reset_progvolt_pin_in, // shared reset pin logic level (async)
	input wire high_prog_voltage_level_in, // high voltage detected on pin (async)
	input wire lv_entry_key_in, // low-voltage entry key seen (async)
	input wire prog_exit_in, // programmer leaves programming mode (async)
	input wire scanner_module_disable_in, // scanner disable control bit
	// external programming port
	input wire ext_req_in, // external access strobe
	input wire ext_wr_in, // 1 write, 0 read
	input wire ext_eeprom_in, // 1 eeprom space, 0 flash space
	input wire [15:0] ext_addr_in, // external address, bit 15 selects id space
	input wire [13:0] ext_wdata_in, // external write data
	output reg [13:0] ext_rdata_out, // external read data
	output reg ext_ack_out, // external access done
	// internal cpu / self-write port
	input wire int_req_in, // internal access strobe
	input wire int_wr_in, // 1 self-write, 0 read
	input wire int_eeprom_in, // 1 eeprom space, 0 flash space
	input wire [15:0] int_addr_in, // internal address, bit 15 selects id space
	input wire [13:0] int_wdata_in, // self-write data
	output reg [13:0] int_rdata_out, // internal read data
	output reg int_ack_out, // internal access done
	// memory array side
	output reg mem_req_out, // array access strobe
	output reg mem_wr_out, // array write enable
	output reg mem_eeprom_out, // array select
	output reg [14:0] mem_addr_out, // array address
	output reg [13:0] mem_wdata_out, // array write data
	input wire [13:0] mem_rdata_in, // array read data, sampled in the strobe cycle
	// status
	output reg in_program_mode_out, // programming mode active
	output reg lv_program_mode_out, // programming via low-voltage entry
	output reg reset_pin_is_reset_out, // shared pin acts as reset
	output reg scanner_enable_out, // scanner running
	output reg lvp_clear_refused_out // one-cycle pulse on refused lvp clear
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RD = 2'h1;
	reg [2:0] pin_s1_q, pin_s2_q;
	reg pv_s1_q, pv_s2_q;
	reg [1:0] state_q;
	reg src_ext_q; // pending read came from external port
	reg blank_q; // pending read returns zeros
	reg [13:0] idval_q; // pending read from id/config space
	reg id_hit_q;
	reg [13:0] uid_q [0:3];
	reg [13:0] mcw_q; // effective memory config word
	wire sel_ext;
	wire [15:0] a;
	wire wr, eep, id_space, uid_hit, flash_prot, eep_prot, self_prot, low_voltage_prog_enable;
	wire [13:0] mcw_rd, cpw_rd, rev_word, wdat;
	wire hv_s, key_s, exit_s;
	wire lvp_clear_try;
	integer i;

	// two-stage sync of pin-side inputs
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
			pv_s1_q <= 1'b1;
			pv_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= {prog_exit_in, lv_entry_key_in, high_prog_voltage_level_in};
			pin_s2_q <= pin_s1_q;
			pv_s1_q <= reset_progvolt_pin_in;
			pv_s2_q <= pv_s1_q;
		end
	end
	assign hv_s = pin_s2_q[0];
	assign key_s = pin_s2_q[1];
	assign exit_s = pin_s2_q[2];
	assign low_voltage_prog_enable = mcw_q[`NVMPI_MCW_LVP_BIT];

	// programming mode entry and exit
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			in_program_mode_out <= 1'b0;
			lv_program_mode_out <= 1'b0;
		end else if (exit_s) begin
			in_program_mode_out <= 1'b0;
			lv_program_mode_out <= 1'b0;
		end else if (!in_program_mode_out && hv_s) begin
			in_program_mode_out <= 1'b1;
			lv_program_mode_out <= 1'b0;
		end else if (!in_program_mode_out && key_s && low_voltage_prog_enable) begin
			in_program_mode_out <= 1'b1;
			lv_program_mode_out <= 1'b1;
		end
	end

	// pin role and scanner gating
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reset_pin_is_reset_out <= 1'b1;
			scanner_enable_out <= 1'b0;
		end else begin
			reset_pin_is_reset_out <= low_voltage_prog_enable | reset_pin_enable_in;
			scanner_enable_out <= mcw_q[`NVMPI_MCW_SCAN_BIT] &
				~scanner_module_disable_in;
		end
	end

	// request select: external always wins
	assign sel_ext = ext_req_in;
	assign a = sel_ext ? ext_addr_in : int_addr_in;
	assign wr = sel_ext ? ext_wr_in : int_wr_in;
	assign eep = sel_ext ? ext_eeprom_in : int_eeprom_in;
	assign wdat = sel_ext ? ext_wdata_in : int_wdata_in;
	assign id_space = !eep && a[15];
	assign uid_hit = id_space && ((a >> 2) == (`NVMPI_UID0_ADDR >> 2));
	assign flash_prot = !code_protect_config_word_in[`NVMPI_CPW_FLASH_BIT];
	assign eep_prot = !code_protect_config_word_in[`NVMPI_CPW_EEP_BIT];
	assign lvp_clear_try = wr && id_space && (a == `NVMPI_MCW_ADDR) &&
		!wdat[`NVMPI_MCW_LVP_BIT];

	nvmpi_wrt_check u_wrt (
		.wrt_field_in(mcw_q[`NVMPI_MCW_WRT_LO+1:`NVMPI_MCW_WRT_LO]),
		.addr_in(a[14:0]),
		.protected_out(self_prot)
	);

	// readback values with unimplemented bits forced high
	assign mcw_rd = mcw_q | `NVMPI_MCW_UNIMP_MASK;
	assign cpw_rd = code_protect_config_word_in | `NVMPI_CPW_UNIMP_MASK;
	assign rev_word = {`NVMPI_REV_FIXED, `NVMPI_MAJOR_REV, `NVMPI_MINOR_REV};

	// access sequencer
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ST_IDLE;
			src_ext_q <= 1'b0;
			blank_q <= 1'b0;
			id_hit_q <= 1'b0;
			idval_q <= 14'h0000;
			mcw_q <= `NVMPI_CFG_RESET;
			mem_req_out <= 1'b0;
			mem_wr_out <= 1'b0;
			mem_eeprom_out <= 1'b0;
			mem_addr_out <= 15'h0000;
			mem_wdata_out <= 14'h0000;
			ext_ack_out <= 1'b0;
			int_ack_out <= 1'b0;
			ext_rdata_out <= 14'h0000;
			int_rdata_out <= 14'h0000;
			lvp_clear_refused_out <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				uid_q[i] <= 14'h0000;
		end else begin
			mem_req_out <= 1'b0;
			mem_wr_out <= 1'b0;
			ext_ack_out <= 1'b0;
			int_ack_out <= 1'b0;
			lvp_clear_refused_out <= 1'b0;
			if (state_q == ST_RD) begin
				state_q <= ST_IDLE;
				if (src_ext_q) begin
					ext_ack_out <= 1'b1;
					ext_rdata_out <= blank_q ? 14'h0000 :
						(id_hit_q ? idval_q : mem_rdata_in);
				end else begin
					int_ack_out <= 1'b1;
					int_rdata_out <= id_hit_q ? idval_q : mem_rdata_in;
				end
			end else if (ext_req_in || int_req_in) begin
				src_ext_q <= sel_ext;
				if (wr) begin
					if (sel_ext) ext_ack_out <= 1'b1;
					else int_ack_out <= 1'b1;
					if (uid_hit) begin
						uid_q[a[1:0]] <= wdat;
					end else if (id_space) begin
						if (sel_ext && a == `NVMPI_MCW_ADDR) begin
							if (lv_program_mode_out && lvp_clear_try) begin
								lvp_clear_refused_out <= 1'b1;
								mcw_q <= {1'b1, wdat[12:0]};
							end else
								mcw_q <= wdat;
						end
						// id words ignore writes
					end else if (sel_ext ? (eep ? eep_prot : flash_prot)
						: (!eep && self_prot)) begin
						// dropped silently
					end else begin
						mem_req_out <= 1'b1;
						mem_wr_out <= 1'b1;
						mem_eeprom_out <= eep;
						mem_addr_out <= a[14:0];
						mem_wdata_out <= wdat;
					end
				end else begin
					state_q <= ST_RD;
					blank_q <= sel_ext && !id_space && (eep ? eep_prot : flash_prot);
					id_hit_q <= id_space;
					case (a)
						`NVMPI_REVID_ADDR: idval_q <= rev_word;
						`NVMPI_DEVICE_IDENTIFIER_ADDR: idval_q <= `NVMPI_PART_CODE;
						`NVMPI_MCW_ADDR: idval_q <= mcw_rd;
						`NVMPI_CPW_ADDR: idval_q <= cpw_rd;
						default: idval_q <= uid_hit ? uid_q[a[1:0]] : 14'h0000;
					endcase
					mem_req_out <= !id_space;
					mem_eeprom_out <= eep;
					mem_addr_out <= a[14:0];
				end
			end
		end
	end
endmodule // nvmpi_top

//--- test/nvmpi_properties.sv
// Purpose: port checks for nvmpi_top
// Assumes: one clock domain
// Notes: bound from the bench top file
`timescale 1ns/10ps
module nvmpi_properties (
	input wire clk_in, // clock
	input wire reset_n_in, // reset
	input wire [13:0] code_protect_config_word_in, // protect word
	input wire ext_req_in, // strobe
	input wire ext_wr_in, // write
	input wire ext_eeprom_in, // space
	input wire [15:0] ext_addr_in, // address
	input wire [13:0] ext_rdata_out, // read data
	input wire ext_ack_out, // ack
	input wire int_ack_out, // ack
	input wire mem_req_out, // array strobe
	input wire reset_pin_is_reset_out, // pin mode
	input wire lv_program_mode_out // lv mode
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// decoded external requests
	wire [13:0] cp = code_protect_config_word_in;
	wire rd = ext_req_in && !ext_wr_in;
	wire fl = !ext_eeprom_in && !ext_addr_in[15];
	wr_ack_a: assert property (ext_req_in && ext_wr_in |=> ext_ack_out ##1 !ext_ack_out)
		else $error("write ack wrong");
	rd_ack_a: assert property (rd |=> !ext_ack_out ##1 ext_ack_out)
		else $error("read ack wrong");
	flash_zero_a: assert property (rd && fl && !cp[0] |-> ##2 ext_rdata_out == 14'h0000)
		else $error("protected flash read not zero");
	ee_zero_a: assert property (rd && ext_eeprom_in && !cp[1] |-> ##2 ext_rdata_out == 14'h0000)
		else $error("protected eeprom read not zero");
	blk_wr_a: assert property (ext_req_in && ext_wr_in && fl && !cp[0] |=> !mem_req_out)
		else $error("blocked write reached array");
	rev_fix_a: assert property (rd && ext_addr_in == 16'h8005 |-> ##2 ext_rdata_out[13:12] == 2'h2)
		else $error("revision fixed bits wrong");
	lv_pin_a: assert property (lv_program_mode_out |-> reset_pin_is_reset_out)
		else $error("pin not reset in lv mode");
	int_ack_a: assert property (int_ack_out |=> !int_ack_out)
		else $error("internal ack too long");
	cover property (rd ##2 ext_ack_out);
	cover property (lv_program_mode_out);
	cover property (int_ack_out);
endmodule // nvmpi_properties

//--- test/nvmpi_mem_model.sv
// Purpose: memory array model behind nvmpi_top
// Assumes: read data wanted in the strobe cycle and the one after
// Notes: unheld data shows a toggling pattern
`timescale 1ns/10ps
module nvmpi_mem_model (
	input wire clk_in, // clock
	input wire req_in, // strobe
	input wire wr_in, // write
	input wire ee_in, // eeprom select
	input wire [14:0] addr_in, // address
	input wire [13:0] wdata_in, // write data
	output wire [13:0] rdata_out // read data
);
	reg [13:0] mem_q [0:16383];
	reg [13:0] last_q;
	reg hold_q;
	// store writes, hold last word one cycle
	always @(posedge clk_in) begin
		hold_q <= req_in;
		last_q <= rdata_out;
		if (req_in && wr_in)
			mem_q[{ee_in, addr_in[12:0]}] <= wdata_in;
	end
	assign rdata_out = req_in ? mem_q[{ee_in, addr_in[12:0]}] : (hold_q ? last_q : ~last_q);
endmodule // nvmpi_mem_model

//--- test/nvmpi_top_bench.sv
// Purpose: self-checking bench for nvmpi_top
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes: array model stands behind the memory port
`timescale 1ns/10ps
`include "nvmpi_consts.vh"
module nvmpi_top_bench;
	reg clk = 1'b0, rst_n = 1'b0, pen = 1'b0, hv = 1'b0, key = 1'b0, pex = 1'b0, sdis = 1'b0;
	reg er = 1'b0, ew = 1'b0, ee = 1'b0, ir = 1'b0, iw = 1'b0, ie = 1'b0, refd = 1'b0;
	reg [15:0] ea = 16'h0000, ia = 16'h0000;
	reg [14:0] a;
	reg [13:0] cpw = 14'h3FFF, ed = 14'h0000, id = 14'h0000, rd_v;
	wire [13:0] erd, ird, mwd, mrd;
	wire [14:0] madr;
	wire eack, iack, mreq, mwr, mee, pm, lvm, rpin, scan, refused;
	integer fail_count = 0, num_checks = 0, f, i, n;
	nvmpi_top u_dut (.clk_in(clk), .reset_n_in(rst_n), .memory_config_word_in(14'h3FFF),
		.code_protect_config_word_in(cpw), .reset_pin_enable_in(pen), .reset_progvolt_pin_in(1'b1),
		.high_prog_voltage_level_in(hv), .lv_entry_key_in(key), .prog_exit_in(pex),
		.scanner_module_disable_in(sdis), .ext_req_in(er), .ext_wr_in(ew), .ext_eeprom_in(ee),
		.ext_addr_in(ea), .ext_wdata_in(ed), .ext_rdata_out(erd), .ext_ack_out(eack),
		.int_req_in(ir), .int_wr_in(iw), .int_eeprom_in(ie), .int_addr_in(ia), .int_wdata_in(id),
		.int_rdata_out(ird), .int_ack_out(iack), .mem_req_out(mreq), .mem_wr_out(mwr),
		.mem_eeprom_out(mee), .mem_addr_out(madr), .mem_wdata_out(mwd), .mem_rdata_in(mrd),
		.in_program_mode_out(pm), .lv_program_mode_out(lvm), .reset_pin_is_reset_out(rpin),
		.scanner_enable_out(scan), .lvp_clear_refused_out(refused));
	nvmpi_mem_model u_mem (.clk_in(clk), .req_in(mreq), .wr_in(mwr), .ee_in(mee),
		.addr_in(madr), .wdata_in(mwd), .rdata_out(mrd));
	// clock and refused-pulse catcher
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (refused) refd <= 1'b1;
	task chk(input string nm, input [13:0] seen, input [13:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// one pulsed access on port p (0 external, 1 internal), bounded wait for ack
	task acc(input p, input w, input e, input [15:0] ad, input [13:0] d);
		begin
			@(negedge clk);
			if (p) {ir, iw, ie, ia, id} = {1'b1, w, e, ad, d};
			else {er, ew, ee, ea, ed} = {1'b1, w, e, ad, d};
			@(negedge clk);
			ir = 1'b0;
			er = 1'b0;
			for (n = 0; n < 8 && (p ? iack : eack) !== 1'b1; n = n + 1) @(negedge clk);
			chk("ack", {13'h0, n == 8}, 14'h0000);
			rd_v = p ? ird : erd;
			@(negedge clk);
		end
	endtask
	task settle(input integer c);
		repeat (c) @(negedge clk);
	endtask
	task results;
		begin
			$display("checks %0d fails %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// watchdog
	initial begin
		#1000000;
		fail_count = fail_count + 1;
		results;
	end
	// main sequence
	initial begin
		settle(16);
		rst_n = 1'b1;
		settle(3);
		chk("pin", {13'h0, rpin}, 14'h0001);
		acc(0, 0, 0, `NVMPI_REVID_ADDR, 0);
		chk("rev", rd_v, {`NVMPI_REV_FIXED, `NVMPI_MAJOR_REV, `NVMPI_MINOR_REV});
		acc(0, 1, 0, `NVMPI_DEVICE_IDENTIFIER_ADDR, ~`NVMPI_PART_CODE);
		acc(1, 0, 0, `NVMPI_DEVICE_IDENTIFIER_ADDR, 0);
		chk("dev", rd_v, `NVMPI_PART_CODE);
		acc(0, 0, 0, `NVMPI_MCW_ADDR, 0);
		chk("mcw", rd_v, 14'h3FFF);
		for (i = 0; i < 4; i = i + 1) acc(1, 1, 0, `NVMPI_UID0_ADDR + i, 14'h1550 + i);
		for (i = 0; i < 4; i = i + 1) begin
			acc(1, 0, 0, `NVMPI_UID0_ADDR + i, 0);
			chk("uid", rd_v, 14'h1550 + i);
		end
		acc(0, 1, 0, 15'h0010, 14'h2AAA);
		acc(0, 1, 1, 15'h0010, 14'h1555);
		for (i = 0; i < 2; i = i + 1) begin
			cpw = i ? 14'h3FFD : 14'h3FFE;
			acc(0, 0, 0, `NVMPI_CPW_ADDR, 0);
			chk("cpw", rd_v, cpw);
			acc(0, 1, i, 15'h0010, 14'h0000);
			acc(0, 0, i, 15'h0010, 0);
			chk("ext", rd_v, 14'h0000);
			acc(0, 0, !i, 15'h0010, 0);
			chk("other", rd_v, i ? 14'h2AAA : 14'h1555);
			acc(1, 0, i, 15'h0010, 0);
			chk("cpu", rd_v, i ? 14'h1555 : 14'h2AAA);
		end
		cpw = 14'h3FFF;
		for (f = 0; f < 4; f = f + 1) begin
			acc(0, 1, 0, `NVMPI_MCW_ADDR, {12'hFFF, f[1:0]});
			for (i = 0; i < 5; i = i + 1) begin
				a = i == 0 ? 15'h01FF : i == 1 ? 15'h0200 : i == 2 ? 15'h0FFF : i == 3 ? 15'h1000 : 15'h1FFF;
				acc(0, 1, 0, a, 14'h0000);
				acc(1, 1, 0, a, {f[1:0], a[11:0]});
				acc(1, 0, 0, a, 0);
				chk("wrt", rd_v, (f == 0 || (f == 1 && a < 15'h1000) || (f == 2 && a < 15'h0200))
					? 14'h0000 : {f[1:0], a[11:0]});
			end
		end
		chk("scan", {13'h0, scan}, 14'h0001);
		sdis = 1'b1;
		settle(3);
		chk("scan", {13'h0, scan}, 14'h0000);
		sdis = 1'b0;
		acc(0, 1, 0, `NVMPI_MCW_ADDR, 14'h2FFF);
		settle(3);
		chk("scan", {13'h0, scan}, 14'h0000);
		key = 1'b1;
		settle(4);
		key = 1'b0;
		chk("lv", {13'h0, lvm}, 14'h0001);
		acc(0, 1, 0, `NVMPI_MCW_ADDR, 14'h1FFF);
		acc(0, 0, 0, `NVMPI_MCW_ADDR, 0);
		chk("lvp", {rd_v[13:12], 11'h0, refd}, 14'h3001);
		pex = 1'b1;
		settle(4);
		pex = 1'b0;
		hv = 1'b1;
		settle(4);
		chk("hv", {12'h0, pm, lvm}, 14'h0002);
		acc(0, 1, 0, `NVMPI_MCW_ADDR, 14'h1FFF);
		settle(3);
		chk("pin", {13'h0, rpin}, 14'h0000);
		pen = 1'b1;
		key = 1'b1;
		settle(4);
		chk("pin", {12'h0, rpin, lvm}, 14'h0002);
		results;
	end
endmodule // nvmpi_top_bench
bind nvmpi_top nvmpi_properties u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.code_protect_config_word_in(code_protect_config_word_in), .ext_req_in(ext_req_in),
	.ext_wr_in(ext_wr_in), .ext_eeprom_in(ext_eeprom_in), .ext_addr_in(ext_addr_in),
	.ext_rdata_out(ext_rdata_out), .ext_ack_out(ext_ack_out), .int_ack_out(int_ack_out),
	.mem_req_out(mem_req_out), .reset_pin_is_reset_out(reset_pin_is_reset_out),
	.lv_program_mode_out(lv_program_mode_out));
